/* verilog/spx_pkg.sv */
`default_nettype none
package spx_pkg;
	// ==============================
	// Register offsets (byte addresses)
	localparam logic [7:0] SPX_OFF_CTRL = 8'h00;
	localparam logic [7:0] SPX_OFF_MODE0 = 8'h04; // Ports 4..1, banks follow
	localparam logic [7:0] SPX_OFF_MODE3 = 8'h10; // Ports 16..13
	localparam logic [7:0] SPX_OFF_SPEED = 8'h14;
	localparam logic [7:0] SPX_OFF_STATUS = 8'h18;
	localparam logic [7:0] SPX_OFF_INDEX = 8'h1C;
	localparam logic [7:0] SPX_OFF_DATA = 8'h20;
	localparam logic [7:0] SPX_OFF_PERIOD = 8'h24;

	// ==============================
	// Field positions
	localparam int SPX_CTRL_START = 0;
	localparam int SPX_CTRL_TRIG = 1;
	localparam int SPX_CTRL_ADDR_LSB = 4;
	localparam int SPX_CTRL_CMD_LSB = 8;
	localparam int SPX_CTRL_CNT_LSB = 16;
	localparam int SPX_CTRL_REPS_LSB = 24;
	localparam int SPX_SPEED_SET = 31;
	localparam int SPX_ST_BUSY = 0;
	localparam int SPX_ST_IRQ = 1;
	localparam int SPX_ST_STALE = 2;
	localparam int SPX_ST_REFUSED = 3;
	localparam int SPX_ST_FAIL_LSB = 16;

	// ==============================
	// Bus addressing and command groups
	localparam logic [3:0] SPX_ADDR_MAX = 4'hE;
	localparam logic [3:0] SPX_ADDR_BCAST = 4'hF;
	localparam logic [7:0] SPX_CMD_MEAS_HI = 8'h45; // 69
	localparam logic [7:0] SPX_CMD_SRC_LO = 8'h46; // 70
	localparam logic [7:0] SPX_CMD_SRC_HI = 8'h55; // 85
	localparam logic [7:0] SPX_CMD_CFG_LO = 8'h56; // 86
	localparam logic [7:0] SPX_CMD_CFG_HI = 8'h5A; // 90
	localparam logic [7:0] SPX_CMD_MEAS_A = 8'h5B; // 91
	localparam logic [7:0] SPX_CMD_MEAS_B = 8'h5C; // 92
	localparam logic [7:0] SPX_CMD_SRC2_LO = 8'h5D; // 93
	localparam logic [7:0] SPX_CMD_SRC2_HI = 8'h62; // 98
	localparam logic [7:0] SPX_CMD_MEAS_C = 8'h63; // 99

	// ==============================
	// Frame layout
	localparam logic [6:0] SPX_HEAD_BITS = 7'd76; // 4 addr + 8 cmd + 64 mode
	localparam logic [6:0] SPX_VAL_BITS = 7'd32;
	localparam logic [1:0] SPX_RETRIES = 2'd3;

	// ==============================
	// Timing
	localparam int SPX_CLK_NS = 40;
	localparam int SPX_RES_NS = 8680; // Bit period resolution step
	localparam int SPX_DEF_NS = 26040; // Default bit period
	localparam int SPX_MAX_NS = 2200000; // Longest bit period
	localparam int SPX_Q_MUL = 72;
	localparam int SPX_Q_DIV = 625;
	localparam logic [23:0] SPX_STEP_CYC = 24'(SPX_RES_NS / SPX_CLK_NS);
	localparam logic [23:0] SPX_DEF_STEPS = 24'(SPX_DEF_NS / SPX_RES_NS);
	localparam logic [23:0] SPX_MIN_STEPS = 24'h000001;
	localparam logic [23:0] SPX_MAX_STEPS = 24'(SPX_MAX_NS / SPX_RES_NS);
	localparam longint SPX_STALE_US = 64'd15937500; // 15.9375 s
	localparam int unsigned SPX_STALE_CYC = 32'(SPX_STALE_US * 1000 / SPX_CLK_NS);

	// ==============================
	// Link phases
	typedef enum logic [2:0] {
		SPX_P_IDLE,
		SPX_P_GAP,
		SPX_P_HEAD,
		SPX_P_VAL,
		SPX_P_ACK
	} spx_phase_t;
endpackage
`default_nettype wire

/* verilog/spx_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// ==============================
// Value buffer, registered read
module spx_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage words, no reset needed

	// Read before write, read data one cycle after address
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule
`default_nettype wire

/* verilog/spx_host_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Measurement commands return values, host accepts
// - Source commands carry host values to module
// - Mode fields zero except configuration commands
// - Four digits per bank, highest port first
// - Modules addressed 0..14; 15 broadcast only
// - Address increments per successive module
// - Status counter zeroed on success, else incremented
// - Programmable bit period, default, min, max
// - Setting zero gives minimum; none gives default
// - Period quantized INT(k*72/625) resolution steps
// - Request measurements more often than 15.9375 s
module spx_host_ctrl
	import spx_pkg::*;
#(
	parameter int unsigned STALE_CYCLES = SPX_STALE_CYC,
	parameter int DEPTH = 16
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic LINK_CLK_OUT,
	output logic LINK_EN_OUT,
	output logic LINK_DATA_OUT,
	output logic LINK_DATA_OE,
	input wire logic LINK_DATA_IN,
	input wire logic LINK_IRQ_IN
);
	// ==============================
	// Command group decoding
	function automatic logic spx_is_meas(input logic [7:0] c);
		return (c != 8'h00 && c <= SPX_CMD_MEAS_HI) || c == SPX_CMD_MEAS_A ||
			c == SPX_CMD_MEAS_B || c == SPX_CMD_MEAS_C;
	endfunction

	function automatic logic spx_is_src(input logic [7:0] c);
		return (c >= SPX_CMD_SRC_LO && c <= SPX_CMD_SRC_HI) ||
			(c >= SPX_CMD_SRC2_LO && c <= SPX_CMD_SRC2_HI);
	endfunction

	function automatic logic spx_is_cfg(input logic [7:0] c);
		return c >= SPX_CMD_CFG_LO && c <= SPX_CMD_CFG_HI;
	endfunction

	// Bit period in core cycles from the speed setting
	function automatic logic [15:0] spx_period(input logic [15:0] k, input logic set);
		logic [23:0] steps;
		steps = ({8'h00, k} * 24'(SPX_Q_MUL)) / 24'(SPX_Q_DIV);
		if (!set) begin
			steps = SPX_DEF_STEPS;
		end else if (steps < SPX_MIN_STEPS) begin
			steps = SPX_MIN_STEPS;
		end else if (steps > SPX_MAX_STEPS) begin
			steps = SPX_MAX_STEPS;
		end
		return 16'(steps * SPX_STEP_CYC);
	endfunction

	// ==============================
	// State
	typedef struct packed {
		logic apb_ack; // Access phase answered next edge
		logic [31:0] prdata; // Read data held for the bus
		logic pslverr;
		logic [7:0] cmd; // Command code
		logic [3:0] addr; // First module_bus_address
		logic [4:0] cnt; // Values per module
		logic [3:0] reps; // Modules served by one command
		logic [63:0] mode; // Bank 3 in top bits
		logic [15:0] spd_k; // bus_bit_period_setting
		logic spd_set; // Setting given at all
		logic [3:0] idx; // Software buffer pointer
		logic refused; // Last start refused
		logic [15:0] fail_cnt; // Status counter
		logic [31:0] stale_cnt; // Time since last measurement
		logic irq_s1, irq_s2; // Interrupt line synchroniser
		logic din_s1, din_s2; // Data line synchroniser
		spx_phase_t phase;
		logic trig; // broadcast_trigger_op frame
		logic [15:0] period; // bit_period_value in cycles
		logic [15:0] tcnt; // Position inside a bit
		logic [75:0] sh; // Frame shifter, MSB first
		logic [6:0] bits; // Bits left in field
		logic [4:0] vals; // Values left in module
		logic [3:0] mods; // Modules left
		logic [3:0] cur; // Current bus address
		logic [3:0] base; // Buffer index of module start
		logic [3:0] maddr; // Link buffer pointer
		logic [1:0] retry;
		logic en, dout, doe, clk; // Link pin drivers
	} spx_state_t;

	spx_state_t st_reg, st_next;
	logic mem_we; // Buffer write strobe
	logic [3:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_q; // Buffer word at previous address

	spx_mem #(.WIDTH(32), .DEPTH(DEPTH), .AW(4)) u_mem (
		.clk(CORE_CLK),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_q)
	);

	// ==============================
	// Next-state logic
	always_comb begin
		logic busy;
		logic tick;
		logic acc;
		logic [75:0] shn;
		logic wr;
		busy = st_reg.phase != SPX_P_IDLE;
		tick = st_reg.tcnt == st_reg.period - 16'h0001;
		acc = PSEL && PENABLE;
		wr = acc && st_reg.apb_ack && PWRITE;
		shn = {st_reg.sh[74:0], st_reg.din_s2};
		st_next = st_reg;
		mem_we = 1'b0;
		mem_wdata = PWDATA;
		mem_addr = busy ? st_reg.maddr : st_reg.idx;

		// Pin synchronisers, second stage only is read
		st_next.irq_s1 = LINK_IRQ_IN;
		st_next.irq_s2 = st_reg.irq_s1;
		st_next.din_s1 = LINK_DATA_IN;
		st_next.din_s2 = st_reg.din_s1;

		// Staleness counter saturates
		if (st_reg.stale_cnt < STALE_CYCLES) begin
			st_next.stale_cnt = st_reg.stale_cnt + 32'h00000001;
		end

		// APB: one wait state, read data captured first cycle
		st_next.apb_ack = acc && !st_reg.apb_ack;
		if (acc && !st_reg.apb_ack) begin
			st_next.pslverr = 1'b0;
			st_next.prdata = 32'h00000000;
			unique case (PADDR)
				SPX_OFF_CTRL: st_next.prdata = {4'h0, st_reg.reps, 3'h0, st_reg.cnt,
					st_reg.cmd, st_reg.addr, 2'h0, st_reg.trig, 1'b0};
				SPX_OFF_SPEED: st_next.prdata = {st_reg.spd_set, 15'h0000, st_reg.spd_k};
				SPX_OFF_STATUS: st_next.prdata = {st_reg.fail_cnt, 12'h000, st_reg.refused,
					st_reg.stale_cnt >= STALE_CYCLES, st_reg.irq_s2, busy};
				SPX_OFF_INDEX: st_next.prdata = {28'h0000000, st_reg.idx};
				SPX_OFF_DATA: begin
					// Buffer belongs to the link while busy
					st_next.prdata = busy ? 32'h00000000 : mem_q;
					st_next.pslverr = busy;
				end
				SPX_OFF_PERIOD: st_next.prdata = {16'h0000, st_reg.period};
				default: begin
					if (PADDR >= SPX_OFF_MODE0 && PADDR <= SPX_OFF_MODE3 && PADDR[1:0] == 2'h0) begin
						st_next.prdata = {16'h0000, st_reg.mode[6'(PADDR[4:2] - 3'h1) * 16 +: 16]};
					end else begin
						st_next.pslverr = 1'b1; // Unmapped
					end
				end
			endcase
		end

		// Read side effect: DATA read advances pointer
		if (acc && st_reg.apb_ack && !PWRITE && PADDR == SPX_OFF_DATA && !busy) begin
			st_next.idx = st_reg.idx + 4'h1;
		end

		// Writes take effect at the answering edge
		if (wr) begin
			if (PADDR >= SPX_OFF_MODE0 && PADDR <= SPX_OFF_MODE3 && PADDR[1:0] == 2'h0 && !busy) begin
				st_next.mode[6'(PADDR[4:2] - 3'h1) * 16 +: 16] = PWDATA[15:0];
			end
			unique case (PADDR)
				SPX_OFF_SPEED: begin
					st_next.spd_k = PWDATA[15:0];
					st_next.spd_set = 1'b1;
					// Idle write shows the new period at once; a busy one waits for the next start
					if (!busy) begin
						st_next.period = spx_period(PWDATA[15:0], 1'b1);
					end
				end
				SPX_OFF_INDEX: st_next.idx = PWDATA[3:0];
				SPX_OFF_DATA: begin
					if (!busy) begin
						mem_we = 1'b1;
						st_next.idx = st_reg.idx + 4'h1;
					end
				end
				SPX_OFF_CTRL: begin
					if (!busy) begin
						st_next.cmd = PWDATA[SPX_CTRL_CMD_LSB +: 8];
						st_next.addr = PWDATA[SPX_CTRL_ADDR_LSB +: 4];
						st_next.cnt = PWDATA[SPX_CTRL_CNT_LSB +: 5];
						st_next.reps = PWDATA[SPX_CTRL_REPS_LSB +: 4];
						st_next.trig = PWDATA[SPX_CTRL_TRIG];
						if (PWDATA[SPX_CTRL_START]) begin
							st_next.mods = (PWDATA[SPX_CTRL_REPS_LSB +: 4] == 4'h0) ? 4'h1 :
								PWDATA[SPX_CTRL_REPS_LSB +: 4];
							// Whole address run must stay at 14 or below
							st_next.refused = !PWDATA[SPX_CTRL_TRIG] &&
								(5'(PWDATA[SPX_CTRL_ADDR_LSB +: 4]) + 5'(st_next.mods) - 5'h01 >
								5'(SPX_ADDR_MAX));
							if (!st_next.refused) begin
								st_next.phase = SPX_P_GAP;
								st_next.period = spx_period(st_reg.spd_k, st_reg.spd_set);
								st_next.tcnt = 16'h0000;
								st_next.cur = PWDATA[SPX_CTRL_TRIG] ? SPX_ADDR_BCAST :
									PWDATA[SPX_CTRL_ADDR_LSB +: 4];
								st_next.base = 4'h0;
								st_next.retry = 2'h0;
							end
						end
					end
				end
				default: ;
			endcase
		end

		// Bit timer runs while a frame sequence is active
		if (busy) begin
			st_next.tcnt = tick ? 16'h0000 : st_reg.tcnt + 16'h0001;
		end

		// Link sequencing
		unique case (st_reg.phase)
			SPX_P_IDLE: ;
			SPX_P_GAP: begin
				// One idle bit with enable low between frames
				if (tick) begin
					if (st_reg.mods == 4'h0) begin
						st_next.phase = SPX_P_IDLE;
					end else begin
						st_next.phase = SPX_P_HEAD;
						st_next.en = 1'b1;
						st_next.doe = 1'b1;
						st_next.bits = SPX_HEAD_BITS;
						st_next.vals = st_reg.cnt;
						st_next.maddr = st_reg.base;
						// Modes only with configuration commands
						st_next.sh = {st_reg.cur, st_reg.trig ? 8'h00 : st_reg.cmd,
							(spx_is_cfg(st_reg.cmd) && !st_reg.trig) ? st_reg.mode : 64'h0};
						st_next.dout = st_reg.cur[3];
					end
				end
			end
			SPX_P_HEAD, SPX_P_VAL: begin
				if (tick) begin
					st_next.sh = shn;
					st_next.bits = st_reg.bits - 7'h01;
					st_next.dout = shn[75];
					if (st_reg.phase == SPX_P_VAL && spx_is_meas(st_reg.cmd) && st_reg.bits == 7'h01) begin
						mem_we = 1'b1;
						mem_wdata = shn[31:0];
						st_next.maddr = st_reg.maddr + 4'h1;
					end
					if (st_reg.bits == 7'h01) begin
						if (st_reg.trig) begin
							// Broadcast has no responder
							st_next.mods = 4'h0;
							st_next.phase = SPX_P_GAP;
							st_next.en = 1'b0;
							st_next.doe = 1'b0;
						end else if (st_next.vals != 5'h00) begin
							st_next.phase = SPX_P_VAL;
							st_next.vals = st_reg.vals - 5'h01;
							st_next.bits = SPX_VAL_BITS;
							st_next.doe = spx_is_src(st_reg.cmd);
							if (spx_is_src(st_reg.cmd)) begin
								st_next.sh = {mem_q, 44'h0};
								st_next.dout = mem_q[31];
								st_next.maddr = st_reg.maddr + 4'h1;
							end
						end else begin
							st_next.phase = SPX_P_ACK;
							st_next.doe = 1'b0;
						end
					end
				end
			end
			SPX_P_ACK: begin
				// Device answers high for a good exchange
				if (tick) begin
					st_next.phase = SPX_P_GAP;
					st_next.en = 1'b0;
					if (st_reg.din_s2 || st_reg.retry == SPX_RETRIES) begin
						st_next.fail_cnt = st_reg.din_s2 ? 16'h0000 :
							((st_reg.fail_cnt == 16'hFFFF) ? st_reg.fail_cnt :
							st_reg.fail_cnt + 16'h0001);
						if (st_reg.din_s2 && spx_is_meas(st_reg.cmd)) begin
							st_next.stale_cnt = 32'h00000000;
						end
						st_next.mods = st_reg.mods - 4'h1;
						st_next.cur = st_reg.cur + 4'h1;
						st_next.base = st_reg.maddr;
						st_next.retry = 2'h0;
					end else begin
						st_next.retry = st_reg.retry + 2'h1;
					end
				end
			end
			default: st_next.phase = SPX_P_IDLE;
		endcase

		// Link clock high in second half of each header, value and ack bit; low through gap bits
		st_next.clk = (st_next.phase == SPX_P_HEAD || st_next.phase == SPX_P_VAL ||
			st_next.phase == SPX_P_ACK) && (st_next.tcnt >= {1'b0, st_next.period[15:1]});
	end

	// ==============================
	// State register, synchronous reset
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			st_reg <= '0;
			st_reg.phase <= SPX_P_IDLE;
			st_reg.period <= 16'(SPX_DEF_STEPS * SPX_STEP_CYC);
		end else begin
			st_reg <= st_next;
		end
	end

	// ==============================
	// Outputs
	assign PRDATA = st_reg.prdata;
	assign PREADY = st_reg.apb_ack;
	assign PSLVERR = st_reg.pslverr && st_reg.apb_ack;
	assign LINK_CLK_OUT = st_reg.clk;
	assign LINK_EN_OUT = st_reg.en;
	assign LINK_DATA_OUT = st_reg.dout;
	assign LINK_DATA_OE = st_reg.doe;
endmodule
`default_nettype wire

/* tb/spx_host_ctrl_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ==============================
// Port checks
module spx_hc_props(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic LINK_CLK_OUT,
	input wire logic LINK_EN_OUT,
	input wire logic LINK_DATA_OUT,
	input wire logic LINK_DATA_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	logic [15:0] hi_reg; // Cycles of link clock high
	// High phase length, shortest bit bounds it
	always_ff @(posedge CORE_CLK) begin
		hi_reg <= (SYS_RST || !LINK_CLK_OUT) ? 16'h0000 : hi_reg + 16'h0001;
	end
	// Setup, then a first access cycle
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_access;
		PSEL && PENABLE && !PREADY;
	endsequence
	apb_wait_a: assert property (s_setup ##1 s_access |=> PREADY) else $error("no answer after one wait");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
	err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	unmapped_err_a: assert property (PREADY && !PWRITE && PADDR > 8'h24 |-> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped read accepted");
	clk_idle_a: assert property (!LINK_EN_OUT |-> !LINK_CLK_OUT) else $error("link clock outside frame");
	oe_frame_a: assert property (LINK_DATA_OE |-> LINK_EN_OUT) else $error("drive outside frame");
	data_hold_a: assert property (LINK_CLK_OUT && LINK_DATA_OE |-> $stable(LINK_DATA_OUT))
		else $error("data moved while clock high");
	half_bit_a: assert property ($fell(LINK_CLK_OUT) |-> hi_reg >= 16'h006C) else $error("bit too short");
endmodule
bind spx_host_ctrl spx_hc_props i_props(.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .LINK_CLK_OUT(LINK_CLK_OUT), .LINK_EN_OUT(LINK_EN_OUT),
	.LINK_DATA_OUT(LINK_DATA_OUT), .LINK_DATA_OE(LINK_DATA_OE));
`default_nettype wire

/* tb/spx_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==============================
// Far-end device on the link
module spx_dev_model(
	input wire logic LINK_CLK_OUT,
	input wire logic LINK_EN_OUT,
	input wire logic LINK_DATA_OUT,
	input wire logic [31:0] VAL,
	input wire logic [4:0] NV,
	input wire logic NAK,
	output logic DATA,
	output logic [75:0] HDR
);
	int n = 0; // Bits seen this frame
	int v; // Value bit slot
	initial DATA = 1'b0;
	initial HDR = '0;
	// Frame end restarts the count
	always @(negedge LINK_EN_OUT) n = 0;
	// Host bits taken at mid-bit rise, first bit ends on top
	always @(posedge LINK_CLK_OUT) begin
		if (LINK_EN_OUT && n < 76) HDR <= {HDR[74:0], LINK_DATA_OUT};
		n = n + 1;
	end
	// Drive at bit start; released line shows the inverse, never a held level
	always @(negedge LINK_CLK_OUT) begin
		v = n - 76;
		if (LINK_EN_OUT && v >= 0 && v < 32 * NV) DATA <= VAL[31 - v % 32];
		else if (LINK_EN_OUT && v == 32 * NV) DATA <= ~NAK;
		else DATA <= ~DATA;
	end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ==============================
// Bench top
module tb import spx_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, irq = 1'b0, nak = 1'b0, er;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, rd, val = 32'hA5C30F96;
	logic [4:0] nv = 5'h00;
	logic [31:0] ks[3] = '{32'h14, 32'hFFFF, 32'h0}; // Speed settings
	logic [31:0] ps[3] = '{32'h1B2, 32'hD675, 32'hD9}; // Cycles per bit
	// Mode banks, ports 4-1 first; every defined digit appears once at least
	logic [15:0] mb[4] = '{16'h2222, 16'h3210, 16'h0145, 16'h9213};
	wire [31:0] prdata;
	wire [75:0] hdr;
	wire prdy, perr, lclk, len, ldo, loe, ldi;
	int bad_count = 0, n_compared = 0;
	spx_host_ctrl #(.STALE_CYCLES(2000)) i_spx_host_ctrl(.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prdata), .PREADY(prdy),
		.PSLVERR(perr), .LINK_CLK_OUT(lclk), .LINK_EN_OUT(len), .LINK_DATA_OUT(ldo),
		.LINK_DATA_OE(loe), .LINK_DATA_IN(ldi), .LINK_IRQ_IN(irq));
	spx_dev_model u_dev(.LINK_CLK_OUT(lclk), .LINK_EN_OUT(len), .LINK_DATA_OUT(ldo), .VAL(val),
		.NV(nv), .NAK(nak), .DATA(ldi), .HDR(hdr));
	// 25 MHz core clock
	always #20 clk = ~clk;
	// One APB transfer, held until ready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// No cycle count assumed; only the watchdog ends this wait
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Compare one word
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Poll busy; long frames, so the watchdog bounds it too
	task automatic wait_idle();
		int i;
		i = 0;
		do begin
			apb(1'b0, SPX_OFF_STATUS, 32'h0);
			i++;
		end while (rd[0] !== 1'b0 && i < 40000);
		chk("busy", 32'h0, {31'h0, rd[0]});
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Watchdog, a little beyond four header attempts and one value frame
	initial begin
		repeat (98000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
	// Test sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, SPX_OFF_PERIOD, 32'h0);
		chk("period", 32'h28B, rd);
		irq <= 1'b1;
		apb(1'b0, SPX_OFF_STATUS, 32'h0);
		chk("status", 32'h2, rd);
		irq <= 1'b0;
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("test reset and map done");
		foreach (ks[i]) begin
			apb(1'b1, SPX_OFF_SPEED, ks[i]);
			apb(1'b0, SPX_OFF_PERIOD, 32'h0);
			chk("period", ps[i], rd);
		end
		$display("test speed done");
		foreach (mb[i]) apb(1'b1, SPX_OFF_MODE0 + 8'(4 * i), {16'h0, mb[i]});
		nak <= 1'b1;
		apb(1'b1, SPX_OFF_CTRL, 32'h00005651);
		wait_idle();
		chk("hdr addr cmd", 32'h556, {20'h0, hdr[75:64]});
		chk("hdr modes hi", 32'h92130145, hdr[63:32]);
		chk("hdr modes lo", 32'h32102222, hdr[31:0]);
		apb(1'b0, SPX_OFF_STATUS, 32'h0);
		chk("fail count", 32'h1, {16'h0, rd[31:16]});
		chk("stale", 32'h4, rd & 32'h4);
		apb(1'b0, SPX_OFF_MODE3, 32'h0);
		chk("mode bank", 32'h9213, rd);
		apb(1'b1, SPX_OFF_CTRL, 32'h020001E1);
		apb(1'b0, SPX_OFF_STATUS, 32'h0);
		chk("refused", 32'h8, rd & 32'h9);
		apb(1'b0, SPX_OFF_CTRL, 32'h0);
		chk("ctrl", 32'h020001E0, rd);
		nak <= 1'b0;
		nv <= 5'h01;
		apb(1'b1, SPX_OFF_CTRL, 32'h00010131);
		apb(1'b0, SPX_OFF_DATA, 32'h0);
		chk("busy data err", 32'h1, {31'h0, er});
		wait_idle();
		chk("hdr addr cmd", 32'h301, {20'h0, hdr[75:64]});
		chk("hdr modes", 32'h0, hdr[63:32] | hdr[31:0]);
		apb(1'b0, SPX_OFF_STATUS, 32'h0);
		chk("fail count", 32'h0, {16'h0, rd[31:16]});
		chk("stale", 32'h0, rd & 32'h4);
		apb(1'b1, SPX_OFF_INDEX, 32'h0);
		apb(1'b0, SPX_OFF_DATA, 32'h0);
		chk("value", val, rd);
		apb(1'b1, SPX_OFF_CTRL, 32'h00000002);
		apb(1'b0, SPX_OFF_CTRL, 32'h0);
		chk("ctrl trig", 32'h2, rd);
		$display("test frames done");
		wrap_up();
	end
endmodule
`default_nettype wire
